// ---- rtl/pmrc_top.sv ----
// Power monitor, oscillator-stop reset and override control with AHB-Lite registers
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pmrc_top #(
  parameter int          OSC_SETTLE_CYCLES = pmrc_pkg::PMRC_OSC_SETTLE_CYC,
  parameter int          TREC_CYCLES       = pmrc_pkg::PMRC_TREC_CYC,
  parameter int          PAT_LEN           = pmrc_pkg::PMRC_PAT_LEN,
  parameter logic [7:0]  PATTERN           = pmrc_pkg::PMRC_PATTERN
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        on_battery_in,
  input  wire logic        battery_low_in,
  input  wire logic        power_fail_sense_in,
  input  wire logic        osc_running_in,
  input  wire logic        sda_ce_in,
  input  wire logic        scl_in,
  output logic             power_fail_out_n_o,
  output logic             power_fail_out_n_oe,
  output logic             chip_reset_n_out,
  output logic             irq_out,
  output logic             square_wave_enable,
  output logic             hour_24_mode
);
  import pmrc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end else begin
      sync1_ff <= {scl_in, sda_ce_in, osc_running_in, power_fail_sense_in,
                   battery_low_in, on_battery_in};
      sync2_ff <= sync1_ff;
    end
  end

  wire on_bat_s  = sync2_ff[0];
  wire blow_s    = sync2_ff[1];
  wire pf_below  = sync2_ff[2];
  wire osc_run_s = sync2_ff[3];
  // Pattern steps hold {data/chip-enable, serial clock}, so order the pair to match
  wire [1:0] pins_s = {sync2_ff[4], sync2_ff[5]};

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  logic       wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] ctrl_ff;
  logic [6:0] stat_val;

  wire        req     = hsel & hready & htrans[1];
  wire [7:0]  a_lo    = haddr[7:0];
  wire        hit_ctrl = (a_lo == PMRC_CTRL_ADDR);
  wire        hit_stat = (a_lo == PMRC_STAT_ADDR);
  wire        wr_ctrl = wr_pend_ff & (wr_addr_ff == PMRC_CTRL_ADDR);
  wire        wr_stat = wr_pend_ff & (wr_addr_ff == PMRC_STAT_ADDR);
  wire [31:0] rd_val  = hit_ctrl ? {24'h000000, ctrl_ff} :
                        hit_stat ? {25'h0000000, stat_val} : 32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata     <= 32'h00000000;
    end else begin
      wr_pend_ff <= req & hwrite;
      wr_addr_ff <= a_lo;
      if (req && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator settle and internal reset state
  pmrc_rst_t  rst_ff;
  pmrc_rst_t  nxt_rst;
  logic [31:0] settle_ff;
  logic        ovrd_hit;

  // Start-up counts as stopped until the oscillator has run the full settle time
  wire settled  = (settle_ff >= 32'(OSC_SETTLE_CYCLES)); // see R13
  wire osc_lost = ~osc_run_s;
  wire ovrd_en  = ctrl_ff[PMRC_C_OVRD_EN];

  always_comb begin
    nxt_rst = rst_ff;
    case (rst_ff)
      PMRC_POR: begin
        if (ovrd_en && ovrd_hit) begin
          nxt_rst = PMRC_OVRD; // see R16 see R17
        end else if (settled) begin
          nxt_rst = PMRC_RUN; // see R11
        end
      end
      PMRC_RUN: begin
        if (osc_lost) begin
          nxt_rst = PMRC_POR; // see R10
        end
      end
      PMRC_OVRD: begin
        if (!ovrd_en) begin
          nxt_rst = settled ? PMRC_RUN : PMRC_POR; // see R18
        end
      end
      default: nxt_rst = PMRC_POR;
    endcase
  end

  wire in_reset  = (rst_ff == PMRC_POR);
  wire rst_entry = (nxt_rst == PMRC_POR) & (rst_ff != PMRC_POR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_ff           <= PMRC_POR;
      settle_ff        <= 32'h00000000;
      chip_reset_n_out <= 1'b0;
    end else begin
      rst_ff           <= nxt_rst;
      chip_reset_n_out <= (nxt_rst != PMRC_POR); // see R11
      if (osc_lost) begin
        settle_ff <= 32'h00000000;
      end else if (!settled) begin
        settle_ff <= settle_ff + 32'h00000001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Override pin sequence detector
  logic [1:0] pins_d_ff;
  logic [3:0] pat_idx_ff;
  logic [3:0] nxt_idx;

  function automatic logic [1:0] pat_step(input logic [3:0] i);
    pat_step = PATTERN[2*i +: 2];
  endfunction

  wire pins_chg = (pins_s != pins_d_ff);
  assign ovrd_hit = (pat_idx_ff == 4'(PAT_LEN)); // see R21

  always_comb begin
    nxt_idx = pat_idx_ff;
    if (!in_reset || !ovrd_en) begin
      nxt_idx = 4'h0; // see R19
    end else if (pins_chg && !ovrd_hit) begin
      if (pins_s == pat_step(pat_idx_ff)) begin
        nxt_idx = pat_idx_ff + 4'h1;
      end else if (pins_s == pat_step(4'h0)) begin
        nxt_idx = 4'h1;
      end else begin
        nxt_idx = 4'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_d_ff  <= 2'h0;
      pat_idx_ff <= 4'h0;
    end else begin
      pins_d_ff  <= pins_s;
      pat_idx_ff <= nxt_idx;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register
  logic [7:0] nxt_ctrl;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = hwdata[7:0];
    end
    if (rst_entry) begin
      nxt_ctrl = PMRC_CTRL_RST; // see R15
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= PMRC_CTRL_RST; // see R15
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign square_wave_enable = ctrl_ff[PMRC_C_SQW_EN];
  assign hour_24_mode       = ctrl_ff[PMRC_C_HOUR24];

  //////////////////////////////////////////////////////////////////////////////
  // Supply flags
  logic bsf_ff;
  logic blf_ff;
  logic osf_ff;
  logic on_bat_d_ff;

  wire switch_en = ctrl_ff[PMRC_C_SWITCH_EN];
  // With switch-over off the battery pin is grounded, so battery is never in use
  wire on_bat    = switch_en & on_bat_s;
  wire bat_rise  = on_bat & ~on_bat_d_ff;
  wire bat_fall  = ~on_bat & on_bat_d_ff;
  wire bsf_clr   = wr_stat & ~hwdata[PMRC_S_BSF];
  wire osf_clr   = wr_stat & ~hwdata[PMRC_S_OSF];
  // Detector level, evaluated on either supply
  wire blf_src   = switch_en & ctrl_ff[PMRC_C_BLOW_EN] & blow_s; // see R2 see R5

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bsf_ff      <= 1'b0;
      blf_ff      <= 1'b0;
      osf_ff      <= 1'b1;
      on_bat_d_ff <= 1'b0;
    end else begin
      on_bat_d_ff <= on_bat;
      if (!switch_en) begin
        bsf_ff <= 1'b0; // see R1
      end else if (bat_rise) begin
        bsf_ff <= 1'b1; // see R20
      end else if (bsf_clr) begin
        bsf_ff <= 1'b0; // see R20
      end
      // Software writes never reach this flag
      blf_ff <= blf_src; // see R4
      if (in_reset || osc_lost) begin
        osf_ff <= 1'b1; // see R10 see R14
      end else if (osf_clr) begin
        osf_ff <= 1'b0; // see R12
      end
    end
  end

  assign irq_out = (blf_ff & ctrl_ff[PMRC_C_BATTERY_LOW_IRQ_ENABLE]) | // see R3
                   (bsf_ff & ctrl_ff[PMRC_C_BSIE]);

  //////////////////////////////////////////////////////////////////////////////
  // Power-fail output with recovery hold-off
  logic [31:0] rec_ff;
  logic        pf_low_ff;

  wire pf_en     = ctrl_ff[PMRC_C_PFAIL_EN];
  wire recovering = (rec_ff != 32'h00000000);
  // Comparator is off on battery and during recovery
  // The fall cycle is masked too, as the recovery count loads only at its end
  wire cmp_on    = ~on_bat & ~recovering & ~bat_fall; // see R8 see R9
  wire nxt_pf_low = pf_en & (on_bat | (cmp_on & pf_below)); // see R6 see R7 see R8

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_ff    <= 32'h00000000;
      pf_low_ff <= 1'b0;
    end else begin
      pf_low_ff <= nxt_pf_low;
      if (on_bat) begin
        rec_ff <= 32'h00000000;
      end else if (bat_fall) begin
        rec_ff <= 32'(TREC_CYCLES); // see R9
      end else if (recovering) begin
        rec_ff <= rec_ff - 32'h00000001;
      end
    end
  end

  // Open drain: only ever pulls low
  assign power_fail_out_n_o  = 1'b0;
  assign power_fail_out_n_oe = pf_low_ff; // see R6

  assign stat_val = {pf_low_ff, on_bat, in_reset, (rst_ff == PMRC_OVRD),
                     osf_ff, blf_ff, bsf_ff};

endmodule // pmrc_top
`default_nettype wire

// ---- rtl/pmrc_pkg.sv ----
// Constants shared by the power monitor and reset control block
//
// Overview of operation
// R1: Battery switch flag reads zero whenever switch-over is disabled.
// R2: Battery-low comparator active sets the battery low flag.
// R3: Battery low flag raises the interrupt only when its enable is set.
// R4: Software cannot clear battery low; it follows the detector only.
// R5: Battery-low detection keeps running while powered from the battery.
// R6: Power-fail output driven low when sense is below reference, else released.
// R7: Switch-over disabled with comparator on: output follows comparator only.
// R8: On switch to battery, comparator off and power-fail output driven low.
// R9: On return to main supply, release output for recovery time, then compare.
// R10: Oscillator loss enters internal reset and sets oscillator stop flag.
// R11: Hold reset and reset pin low until oscillator runs stable.
// R12: Oscillator stop flag stays one until software writes zero.
// R13: Oscillator counts as stopped during the whole start-up settle time.
// R14: Every internal reset sets the oscillator stop flag.
// R15: Internal reset loads defaults: clock out on, 24 hour, detectors enabled.
// R16: Override entry needs enable bit one plus the pin toggle sequence.
// R17: Entering override leaves reset at once, not waiting for oscillator.
// R18: Writing zero to override enable leaves override mode.
// R19: Override enable zero also clears sequence progress; re-entry needs it set again.
// R20: Switch to battery sets battery switch flag; software clears it.
// R21: Pin toggle sequence is matched against a parameterised pattern.
package pmrc_pkg;

  // Byte addresses of the registers
  localparam logic [7:0] PMRC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] PMRC_STAT_ADDR = 8'h04;

  // Control register fields
  localparam int PMRC_C_OVRD_EN   = 0;
  localparam int PMRC_C_BATTERY_LOW_IRQ_ENABLE      = 1;
  localparam int PMRC_C_BSIE      = 2;
  localparam int PMRC_C_SWITCH_EN = 3;
  localparam int PMRC_C_BLOW_EN   = 4;
  localparam int PMRC_C_PFAIL_EN  = 5;
  localparam int PMRC_C_HOUR24    = 6;
  localparam int PMRC_C_SQW_EN    = 7;
  localparam int PMRC_CTRL_W      = 8;

  // Switch-over, detectors, 24 hour and clock out on; override enable off
  localparam logic [7:0] PMRC_CTRL_RST = 8'hf8;

  // Status register fields
  localparam int PMRC_S_BSF      = 0;
  localparam int PMRC_S_BLF      = 1;
  localparam int PMRC_S_OSF      = 2;
  localparam int PMRC_S_OVRD     = 3;
  localparam int PMRC_S_IN_RST   = 4;
  localparam int PMRC_S_ON_BAT   = 5;
  localparam int PMRC_S_PF_LOW   = 6;

  // Timing
  localparam int PMRC_CLK_NS        = 40;
  localparam int PMRC_OSC_SETTLE_MS = 200;
  localparam int PMRC_TREC_MIN_US   = 15630;
  localparam int PMRC_TREC_MAX_US   = 31250;
  localparam int PMRC_OSC_SETTLE_CYC =
    (PMRC_OSC_SETTLE_MS * 1000000 + PMRC_CLK_NS - 1) / PMRC_CLK_NS;
  localparam int PMRC_TREC_CYC =
    (PMRC_TREC_MIN_US * 1000 + PMRC_CLK_NS - 1) / PMRC_CLK_NS;

  // Override pin sequence: {data/chip-enable, serial clock} levels in order
  localparam int          PMRC_PAT_LEN = 4;
  localparam logic [7:0]  PMRC_PATTERN = 8'h1b;

  typedef enum logic [1:0] {
    PMRC_POR,
    PMRC_RUN,
    PMRC_OVRD
  } pmrc_rst_t;

endpackage

// ---- test/pmrc_sva.sv ----
// Checker bound to the power monitor and reset control top
`timescale 1ns/100ps
`default_nettype none
module pmrc_sva #(
  parameter int OSC_SETTLE_CYCLES = 20
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        on_battery_in,
  input wire logic        power_fail_sense_in,
  input wire logic        osc_running_in,
  input wire logic        power_fail_out_n_oe,
  input wire logic        chip_reset_n_out,
  input wire logic        irq_out,
  input wire logic        square_wave_enable,
  input wire logic        hour_24_mode
);
  import pmrc_pkg::*;
  logic       wr_ff;
  logic [7:0] wa_ff;
  logic [7:0] ctrl_ff;
  int         osc_ff;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////
  // Shadow control: bus writes, and the reload on reset entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff   <= 1'b0;
      wa_ff   <= 8'h00;
      ctrl_ff <= PMRC_CTRL_RST;
      osc_ff  <= 0;
    end else begin
      wr_ff  <= hsel & hready & htrans[1] & hwrite;
      wa_ff  <= haddr[7:0];
      osc_ff <= osc_running_in ? osc_ff + int'(osc_ff < 999) : 0;
      if (wr_ff && wa_ff == PMRC_CTRL_ADDR) begin
        ctrl_ff <= hwdata[7:0];
      end else if ($fell(chip_reset_n_out)) begin
        ctrl_ff <= PMRC_CTRL_RST;
      end
    end
  end
  ////////////////////////////////
  rst_settle_a: assert property (
    $rose(chip_reset_n_out) |-> osc_ff >= OSC_SETTLE_CYCLES || ctrl_ff[0])
    else $error("reset released before oscillator settled");
  osc_loss_a: assert property (
    $fell(osc_running_in) && !ctrl_ff[0] |-> ##[1:5] !chip_reset_n_out)
    else $error("oscillator loss did not reset the chip");
  pf_batt_a: assert property (
    (on_battery_in && ctrl_ff[3] && ctrl_ff[5] && chip_reset_n_out) [*4] |-> power_fail_out_n_oe)
    else $error("power fail pin released on battery");
  pf_follow_a: assert property (
    (!ctrl_ff[3] && ctrl_ff[5] && chip_reset_n_out && $stable(power_fail_sense_in)) [*4]
    |-> power_fail_out_n_oe == power_fail_sense_in)
    else $error("power fail pin not following comparator");
  pf_rec_a: assert property (
    $fell(on_battery_in) && ctrl_ff[3] && chip_reset_n_out |-> ##4 (!power_fail_out_n_oe) [*6])
    else $error("power fail pin pulled during recovery");
  irq_gate_a: assert property (
    irq_out |-> ctrl_ff[1] || ctrl_ff[2])
    else $error("interrupt without enable");
  ovrd_exit_a: assert property (
    $fell(ctrl_ff[0]) && osc_ff < OSC_SETTLE_CYCLES |-> ##[0:3] !chip_reset_n_out)
    else $error("override not left");
  rst_mode_a: assert property (
    $rose(hresetn) |-> square_wave_enable && hour_24_mode)
    else $error("default modes missing");
endmodule // pmrc_sva
bind pmrc_top pmrc_sva #(.OSC_SETTLE_CYCLES(OSC_SETTLE_CYCLES)) i_sva (.*);
`default_nettype wire

// ---- test/pmrc_host.sv ----
// Host side model: power fail pull-up and override pin toggling
`timescale 1ns/100ps
`default_nettype none
module pmrc_host (
  input  wire logic hclk,
  input  wire logic power_fail_out_n_o,
  input  wire logic power_fail_out_n_oe,
  output logic      pf_pin,
  output var logic  sda_ce_in,
  output var logic  scl_in
);
  import pmrc_pkg::*;
  // External pull-up holds the pin high while nobody pulls
  assign pf_pin = power_fail_out_n_oe ? power_fail_out_n_o : 1'b1;
  initial begin
    sda_ce_in = 1'b0;
    scl_in    = 1'b0;
  end
  // Each step lasts a full cycle at least, so no level is lost
  task automatic send_pattern(input logic [31:0] s);
    int i;
    for (i = 0; i < PMRC_PAT_LEN; i++) begin
      repeat (s[2*i+:2] + 1) @(posedge hclk);
      {sda_ce_in, scl_in} <= PMRC_PATTERN[2*i+:2];
    end
  endtask
endmodule // pmrc_host
`default_nettype wire

// ---- test/test_power_monitor_reset_control.sv ----
// Self-checking bench for power monitor and reset control
`timescale 1ns/100ps
`default_nettype none
module test_power_monitor_reset_control;
  import pmrc_pkg::*;
  localparam logic [7:0] CA = PMRC_CTRL_ADDR;
  localparam logic [7:0] SA = PMRC_STAT_ADDR;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_ph;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        on_battery_in, battery_low_in, power_fail_sense_in, osc_running_in;
  logic        sda_ce_in, scl_in, power_fail_out_n_o, power_fail_out_n_oe, pf_pin;
  logic        chip_reset_n_out, irq_out, square_wave_enable, hour_24_mode;
  logic [31:0] exp_q[$];
  string       nm_q[$];
  int          miscompares, n_checks;
  assign hready = hreadyout;
  pmrc_top #(.OSC_SETTLE_CYCLES(20), .TREC_CYCLES(10)) i_dut (.*);
  pmrc_host i_host (.*);
  initial hclk = 1'b0;
  always #20 hclk = ~hclk;
  ////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_checks++;
    if (seen !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph  <= ~w;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_ph === 1'b1 && exp_q.size() > 0) begin
      chk(nm_q.pop_front(), hrdata, exp_q.pop_front());
    end
  end
  initial begin
    #(40 * 6000);
    miscompares++;
    end_sim();
  end
  ////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, rd_ph, on_battery_in, battery_low_in} = 6'h0;
    {haddr, hwdata, htrans, power_fail_sense_in, osc_running_in} = 68'h0;
    {hsize, r, miscompares, n_checks} = {3'h2, 32'h3e9d, 64'h0};
    wait_c(20);
    hresetn <= 1'b1;
    chk("modes", 32'({square_wave_enable, hour_24_mode}), 32'h3);
    rd(CA, 32'hf8, "ctrl");
    rd(SA, 32'h14, "status");
    $display("test reset done");
    i_host.send_pattern(r);
    r = lfsr(r);
    wait_c(6);
    rd(SA, 32'h14, "status");
    wr_ovrd: bus(CA, 1'b1, 32'hf9);
    i_host.send_pattern(r);
    r = lfsr(r);
    wait_c(6);
    rd(SA, 32'h0c, "status");
    chk("reset pin", 32'(chip_reset_n_out), 32'h1);
    bus(CA, 1'b1, 32'hf8);
    wait_c(3);
    rd(SA, 32'h14, "status");
    $display("test override done");
    osc_running_in <= 1'b1;
    wait_c(26);
    rd(SA, 32'h04, "status");
    bus(SA, 1'b1, 32'h0);
    rd(SA, 32'h00, "status");
    $display("test oscillator done");
    bus(CA, 1'b1, 32'hfe);
    on_battery_in <= 1'b1;
    wait_c(5);
    rd(SA, 32'h61, "status");
    chk("irq", 32'(irq_out), 32'h1);
    battery_low_in      <= 1'b1;
    power_fail_sense_in <= 1'b1;
    wait_c(5);
    bus(SA, 1'b1, 32'h5);
    rd(SA, 32'h63, "status");
    on_battery_in <= 1'b0;
    wait_c(4);
    rd(SA, 32'h03, "status");
    chk("pf pin", 32'(pf_pin), 32'h1);
    wait_c(14);
    rd(SA, 32'h43, "status");
    bus(CA, 1'b1, 32'hf8);
    @(negedge hclk);
    chk("irq", 32'(irq_out), 32'h0);
    power_fail_sense_in <= 1'b0;
    battery_low_in      <= 1'b0;
    wait_c(5);
    bus(SA, 1'b1, 32'h04);
    rd(SA, 32'h00, "status");
    $display("test battery done");
    bus(CA, 1'b1, 32'hf0);
    {on_battery_in, battery_low_in, power_fail_sense_in} <= 3'h7;
    wait_c(5);
    rd(SA, 32'h40, "status");
    chk("pf pin", 32'(pf_pin), 32'h0);
    power_fail_sense_in <= 1'b0;
    wait_c(5);
    rd(SA, 32'h00, "status");
    {on_battery_in, battery_low_in} <= 2'h0;
    $display("test no switch-over done");
    osc_running_in <= 1'b0;
    wait_c(6);
    rd(SA, 32'h14, "status");
    rd(CA, 32'hf8, "ctrl");
    bus(8'h08, 1'b1, r);
    rd(8'h08, 32'h0, "unmapped");
    rd(CA, 32'hf8, "ctrl");
    $display("test loss and unmapped done");
    end_sim();
  end
endmodule // test_power_monitor_reset_control
`default_nettype wire
